/* testbench/fdcr_drive_model.sv */
// drive and formatter side model: pulses events and holds level qualifiers
`timescale 1ns/1ns
module fdcr_drive_model
  import fdcr_pkg::*;
(
  input wire logic act,
  input wire logic fire,
  input wire fdcr_event_t pat,
  output fdcr_event_t ev
);
  // pulses only while fired, qualifier levels only while a command runs; the cylinder bus is driven at all times
  always_comb begin
    ev = fire ? pat : '0;
    ev.idReadGood = act & pat.idReadGood;
    ev.targetFound = act & pat.targetFound;
    ev.scanMatched = act & pat.scanMatched;
    // id read stays valid through the command so the end check sees it
    ev.idValid = act & pat.idValid;
    // released cylinder bus shows the inverse of its last value
    ev.idCylinder = act ? pat.idCylinder : ~pat.idCylinder;
  end
endmodule : fdcr_drive_model

/* testbench/fdcr_result_flags_tb.sv */
// testbench: apb reads of the error bytes after scripted commands
`timescale 1ns/1ns
module fdcr_result_flags_tb;
  import fdcr_pkg::*;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, se, cmdStart = 0, cmdEnd = 0, writeProtect = 0, act = 0, fire = 0;
  fdcr_cmd_t cmdCode = FDCR_CMD_READ;
  fdcr_event_t ev, pat = '0;
  int n_errors = 0, n_checks = 0;
  fdcr_err1_t ef;
  fdcr_err2_t es;
  logic [1:0] tc;
  logic bz;

  always #5 core_clk = ~core_clk;

  fdcr_result_flags #(.SERVICE_CYC(4)) u_fdcr_result_flags (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmdStart(cmdStart), .cmdCode(cmdCode), .cmdEnd(cmdEnd), .writeProtect(writeProtect),
    .ev(ev), .errFirst(ef), .errSecond(es), .termCode(tc), .busy(bz));
  fdcr_drive_model u_fdcr_drive_model (.act(act), .fire(fire), .pat(pat), .ev(ev));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      stop_test();
    end
    r = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask : apb

  // one command with twice-pulsed events, then read both bytes and the code
  task automatic run(input fdcr_cmd_t c, input logic [14:0] p, input logic [7:0] cy,
                     input logic w, input logic [7:0] e1, input logic [7:0] e2);
    cmdCode <= c;
    cmdStart <= 1;
    pat <= {p, cy};
    writeProtect <= w;
    act <= 1;
    @(posedge core_clk);
    cmdStart <= 0;
    repeat (2) begin
      fire <= 1;
      @(posedge core_clk);
      fire <= 0;
      @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    cmdEnd <= 1;
    @(posedge core_clk);
    cmdEnd <= 0;
    act <= 0;
    writeProtect <= 0;
    repeat (3) @(posedge core_clk);
    apb(0, FDCR_ADDR_ERR1, '0);
    chk(r, {24'h0, e1});
    apb(0, FDCR_ADDR_ERR2, '0);
    chk(r, {24'h0, e2});
    apb(0, FDCR_ADDR_CODE, '0);
    chk(r, {30'h0, ((e1 | e2) != 8'h00) ? FDCR_IC_ABNORMAL : FDCR_IC_NORMAL});
    chk({24'h0, ef}, {24'h0, e1});
    chk({24'h0, es}, {24'h0, e2});
    chk({30'h0, tc}, {30'h0, ((e1 | e2) != 8'h00) ? FDCR_IC_ABNORMAL : FDCR_IC_NORMAL});
    chk({31'h0, bz}, 32'h0);
    $display("test done cmd %0d", c);
  endtask : run

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    apb(0, FDCR_ADDR_ERR1, '0);
    chk(r, 32'h0);
    apb(1, FDCR_ADDR_TARGET, 32'h05);
    apb(0, FDCR_ADDR_TARGET, '0);
    chk(r, 32'h05);
    apb(0, 12'h020, '0);
    chk({se, r}, {1'b1, 32'h0});
    run(FDCR_CMD_READ, 15'h40c0, 8'h05, 0, 8'h80, 8'h00);
    run(FDCR_CMD_READ, 15'h00c1, 8'h05, 0, 8'h00, 8'h00);
    run(FDCR_CMD_READ, 15'h20c0, 8'h05, 0, 8'h20, 8'h00);
    run(FDCR_CMD_READ, 15'h10c0, 8'h05, 0, 8'h20, 8'h20);
    run(FDCR_CMD_READ, 15'h08c0, 8'h05, 0, 8'h10, 8'h00);
    apb(1, FDCR_ADDR_ERR1, 32'hff);
    apb(0, FDCR_ADDR_ERR1, '0);
    chk(r, 32'h10);
    run(FDCR_CMD_READ, 15'h0000, 8'h05, 0, 8'h04, 8'h00);
    run(FDCR_CMD_READ_ID, 15'h0000, 8'h05, 0, 8'h04, 8'h00);
    run(FDCR_CMD_READ_TRACK, 15'h0000, 8'h05, 0, 8'h04, 8'h00);
    run(FDCR_CMD_WRITE, 15'h00c0, 8'h05, 1, 8'h02, 8'h00);
    run(FDCR_CMD_WRITE_DEL, 15'h00c0, 8'h05, 1, 8'h02, 8'h00);
    run(FDCR_CMD_FORMAT, 15'h00c0, 8'h05, 1, 8'h02, 8'h00);
    run(FDCR_CMD_READ, 15'h00c0, 8'h05, 1, 8'h00, 8'h00);
    run(FDCR_CMD_READ, 15'h02c0, 8'h05, 0, 8'h01, 8'h00);
    run(FDCR_CMD_READ, 15'h00e0, 8'h05, 0, 8'h01, 8'h01);
    run(FDCR_CMD_READ, 15'h00d0, 8'h05, 0, 8'h00, 8'h40);
    run(FDCR_CMD_SCAN, 15'h00d0, 8'h05, 0, 8'h00, 8'h40);
    run(FDCR_CMD_READ, 15'h0001, 8'h03, 0, 8'h04, 8'h10);
    run(FDCR_CMD_READ, 15'h0001, 8'hff, 0, 8'h04, 8'h12);
    run(FDCR_CMD_SCAN, 15'h00c8, 8'h05, 0, 8'h00, 8'h08);
    run(FDCR_CMD_SCAN, 15'h00c4, 8'h05, 0, 8'h00, 8'h04);
    run(FDCR_CMD_SCAN, 15'h00c6, 8'h05, 0, 8'h00, 8'h00);
    stop_test();
  end
endmodule : fdcr_result_flags_tb

/* verilog/fdcr_pkg.sv */
// package: register map, flag positions and types for the result error flags block
// Functional notes
// - set end-of-cylinder on sector past last
// - first byte bits 6 and 3 read zero
// - any field CRC fault sets bit 5
// - host service timeout sets overrun bit 4
// - read/deleted-write/scan target sector missing sets bit 2
// - read-id without clean id sets bit 2
// - read-track start sector missing sets bit 2
// - write-protect on writes or format sets bit 1
// - no id mark by second index sets bit 0
// - missing data mark sets both bit 0s
// - second byte bit 7 reads zero
// - deleted mark on read or scan sets bit 6
// - data field CRC fault sets bit 5
// - cylinder mismatch with missing sector sets bit 4
// - scan equal condition sets bit 3
// - scan with no matching sector sets bit 2
// - mismatch reading FF with missing sector sets bit 1
// - missing data mark on read sets bit 0
// - any flag gives abnormal termination code
package fdcr_pkg;
  localparam logic [11:0] FDCR_ADDR_ERR1 = 12'h000;
  localparam logic [11:0] FDCR_ADDR_ERR2 = 12'h004;
  localparam logic [11:0] FDCR_ADDR_CODE = 12'h008;
  localparam logic [11:0] FDCR_ADDR_CTRL = 12'h00c;
  localparam logic [11:0] FDCR_ADDR_TARGET = 12'h010;
  localparam logic [11:0] FDCR_ADDR_STATE = 12'h014;
  localparam logic [7:0] FDCR_BYTE_RST = 8'h00;
  localparam logic [7:0] FDCR_BAD_CYL = 8'hff;
  localparam logic [1:0] FDCR_IC_NORMAL = 2'h0;
  localparam logic [1:0] FDCR_IC_ABNORMAL = 2'h1;
  localparam logic [31:0] FDCR_CTRL_RST = 32'h0000_0000;
  // index pulse count at which a still missing id mark is flagged
  localparam logic [1:0] FDCR_INDEX_LIMIT = 2'h2;
  // default host service window, 13 us, in cycles at 100 MHz
  localparam int FDCR_SERVICE_NS = 13000;
  localparam int FDCR_CLK_NS = 10;
  localparam int FDCR_SERVICE_CYC = FDCR_SERVICE_NS / FDCR_CLK_NS;

  typedef enum logic [3:0] {
    FDCR_CMD_READ = 4'h0,
    FDCR_CMD_READ_DEL = 4'h1,
    FDCR_CMD_WRITE = 4'h2,
    FDCR_CMD_WRITE_DEL = 4'h3,
    FDCR_CMD_FORMAT = 4'h4,
    FDCR_CMD_READ_ID = 4'h5,
    FDCR_CMD_READ_TRACK = 4'h6,
    FDCR_CMD_SCAN = 4'h7
  } fdcr_cmd_t;

  // first error byte, bit 7 down to bit 0
  typedef struct packed {
    logic endCylinder;
    logic unused6;
    logic crcFaultAnyField;
    logic overrun;
    logic unused3;
    logic sectorMissingFlag;
    logic writeBlockedFlag;
    logic idSyncLost;
  } fdcr_err1_t;

  // second error byte, bit 7 down to bit 0
  typedef struct packed {
    logic unused7;
    logic deletedSectorSeen;
    logic payloadCrcFault;
    logic trackNumberMismatch;
    logic compareEqualHit;
    logic compareNoMatch;
    logic damagedTrackFlag;
    logic dataSyncLost;
  } fdcr_err2_t;

  // one-cycle events and held level qualifiers reported by the formatter and drive side
  typedef struct packed {
    logic sectorPastEnd;
    logic idCrcFail;
    logic dataCrcFail;
    logic dataRequest;
    logic hostService;
    logic indexPulse;
    logic idMarkFound;
    logic idReadGood;
    logic targetFound;
    logic dataMarkMissing;
    logic deletedMark;
    logic scanEqual;
    logic scanDone;
    logic scanMatched;
    logic idValid;
    logic [7:0] idCylinder;
  } fdcr_event_t;

  typedef enum logic [1:0] {
    FDCR_IDLE = 2'b00,
    FDCR_EXEC = 2'b01,
    FDCR_RESULT = 2'b11
  } fdcr_state_t;

  function automatic logic isScanOrRead(input fdcr_cmd_t c);
    return (c == FDCR_CMD_READ) || (c == FDCR_CMD_READ_DEL) || (c == FDCR_CMD_SCAN);
  endfunction : isScanOrRead
endpackage : fdcr_pkg

/* verilog/fdcr_result_flags.sv */
// module: result-phase error status bytes with apb access
`timescale 1ns/1ns
module fdcr_result_flags
  import fdcr_pkg::*;
#(
  parameter int SERVICE_CYC = FDCR_SERVICE_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmdStart,
  input wire fdcr_cmd_t cmdCode,
  input wire logic cmdEnd,
  input wire logic writeProtect,
  input wire fdcr_event_t ev,
  output fdcr_err1_t errFirst,
  output fdcr_err2_t errSecond,
  output logic [1:0] termCode,
  output logic busy
);
  initial begin
    if (SERVICE_CYC < 1 || SERVICE_CYC > 65535) $error("SERVICE_CYC out of range");
  end

  fdcr_state_t state_q;
  fdcr_cmd_t cmd_q;
  fdcr_err1_t err1_q;
  fdcr_err2_t err2_q;
  logic [1:0] code_q;
  logic [1:0] indexCnt_q;
  logic idSeen_q;
  logic idGood_q;
  logic reqPending_q;
  logic [15:0] svcCnt_q;
  logic [7:0] targetCyl_q;
  logic setupEnd;
  logic anyErr;
  logic cylMismatch;
  logic isWrite;
  logic svcTimeout;
  logic apbWr;
  logic apbRd;
  logic mapped;

  assign isWrite = (cmd_q == FDCR_CMD_WRITE) || (cmd_q == FDCR_CMD_WRITE_DEL)
                   || (cmd_q == FDCR_CMD_FORMAT);
  assign cylMismatch = ev.idValid && (ev.idCylinder != targetCyl_q);
  assign svcTimeout = reqPending_q && (svcCnt_q == 16'(SERVICE_CYC - 1)) && !ev.hostService;
  assign setupEnd = (state_q == FDCR_EXEC) && cmdEnd;
  assign anyErr = (|err1_q) || (|err2_q);

  // command phase sequencing
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FDCR_IDLE;
      cmd_q <= FDCR_CMD_READ;
    end else if (cmdStart) begin
      state_q <= FDCR_EXEC;
      cmd_q <= cmdCode;
    end else if (setupEnd) begin
      state_q <= FDCR_RESULT;
    end
  end

  // index pulses counted up to the limit while a command executes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      indexCnt_q <= 2'h0;
      idSeen_q <= 1'b0;
      idGood_q <= 1'b0;
    end else if (cmdStart) begin
      indexCnt_q <= 2'h0;
      idSeen_q <= 1'b0;
      idGood_q <= 1'b0;
    end else if (state_q == FDCR_EXEC) begin
      if (ev.idMarkFound) idSeen_q <= 1'b1;
      if (ev.idReadGood) idGood_q <= 1'b1;
      if (ev.indexPulse && indexCnt_q != FDCR_INDEX_LIMIT) indexCnt_q <= indexCnt_q + 2'h1;
    end
  end

  // host service window for each data request
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqPending_q <= 1'b0;
      svcCnt_q <= 16'h0000;
    end else if (cmdStart || state_q != FDCR_EXEC || ev.hostService || svcTimeout) begin
      reqPending_q <= 1'b0;
      svcCnt_q <= 16'h0000;
    end else if (ev.dataRequest) begin
      reqPending_q <= 1'b1;
      svcCnt_q <= 16'h0000;
    end else if (reqPending_q) begin
      svcCnt_q <= svcCnt_q + 16'h0001;
    end
  end

  // first error byte: cleared at command start, set by events while executing
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err1_q <= fdcr_err1_t'(FDCR_BYTE_RST);
    end else if (cmdStart) begin
      err1_q <= fdcr_err1_t'(FDCR_BYTE_RST);
    end else if (state_q == FDCR_EXEC) begin
      if (ev.sectorPastEnd) err1_q.endCylinder <= 1'b1;
      if (ev.idCrcFail || ev.dataCrcFail) err1_q.crcFaultAnyField <= 1'b1;
      if (svcTimeout) err1_q.overrun <= 1'b1;
      if (cmdEnd && !ev.targetFound && (isScanOrRead(cmd_q) || cmd_q == FDCR_CMD_WRITE_DEL))
        err1_q.sectorMissingFlag <= 1'b1;
      if (cmdEnd && cmd_q == FDCR_CMD_READ_ID && !idGood_q && !ev.idReadGood)
        err1_q.sectorMissingFlag <= 1'b1;
      if (cmdEnd && cmd_q == FDCR_CMD_READ_TRACK && !ev.targetFound)
        err1_q.sectorMissingFlag <= 1'b1;
      if (isWrite && writeProtect) err1_q.writeBlockedFlag <= 1'b1;
      if (ev.indexPulse && !idSeen_q && !ev.idMarkFound
          && indexCnt_q == FDCR_INDEX_LIMIT - 2'h1)
        err1_q.idSyncLost <= 1'b1;
      if (ev.dataMarkMissing) err1_q.idSyncLost <= 1'b1;
    end
  end

  // second error byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err2_q <= fdcr_err2_t'(FDCR_BYTE_RST);
    end else if (cmdStart) begin
      err2_q <= fdcr_err2_t'(FDCR_BYTE_RST);
    end else if (state_q == FDCR_EXEC) begin
      if (ev.deletedMark && isScanOrRead(cmd_q)) err2_q.deletedSectorSeen <= 1'b1;
      if (ev.dataCrcFail) err2_q.payloadCrcFault <= 1'b1;
      if (cmdEnd && !ev.targetFound && cylMismatch)
        err2_q.trackNumberMismatch <= 1'b1;
      if (cmd_q == FDCR_CMD_SCAN && ev.scanEqual) err2_q.compareEqualHit <= 1'b1;
      if (cmd_q == FDCR_CMD_SCAN && ev.scanDone && !ev.scanMatched)
        err2_q.compareNoMatch <= 1'b1;
      if (cmdEnd && !ev.targetFound && cylMismatch && ev.idCylinder == FDCR_BAD_CYL)
        err2_q.damagedTrackFlag <= 1'b1;
      if (ev.dataMarkMissing) err2_q.dataSyncLost <= 1'b1;
    end
  end

  // interrupt code latched when the command finishes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_q <= FDCR_IC_NORMAL;
    end else if (cmdStart) begin
      code_q <= FDCR_IC_NORMAL;
    end else if (state_q == FDCR_RESULT) begin
      code_q <= anyErr ? FDCR_IC_ABNORMAL : FDCR_IC_NORMAL;
    end
  end

  // apb: zero wait, writes take effect at the access edge
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !pwrite;
  assign mapped = (paddr == FDCR_ADDR_ERR1) || (paddr == FDCR_ADDR_ERR2)
                  || (paddr == FDCR_ADDR_CODE) || (paddr == FDCR_ADDR_TARGET)
                  || (paddr == FDCR_ADDR_STATE) || (paddr == FDCR_ADDR_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // target cylinder written by software
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      targetCyl_q <= FDCR_CTRL_RST[7:0];
    end else if (apbWr && paddr == FDCR_ADDR_TARGET) begin
      targetCyl_q <= pwdata[7:0];
    end
  end

  // read data registered in the setup cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (apbRd && !penable) begin
      case (paddr)
        FDCR_ADDR_ERR1: prdata <= {24'h000000, err1_q};
        FDCR_ADDR_ERR2: prdata <= {24'h000000, err2_q};
        FDCR_ADDR_CODE: prdata <= {30'h0, code_q};
        FDCR_ADDR_TARGET: prdata <= {24'h000000, targetCyl_q};
        FDCR_ADDR_STATE: prdata <= {30'h0, state_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign errFirst = err1_q;
  assign errSecond = err2_q;
  assign termCode = code_q;
  assign busy = (state_q == FDCR_EXEC);

  // assertions
  a_first_unused_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 (!err1_q.unused6 && !err1_q.unused3)) else $error("unused first bits set");
  a_second_unused_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ##1 !err2_q.unused7) else $error("unused second bit set");
  a_past_end_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && ev.sectorPastEnd) |=> err1_q.endCylinder)
    else $error("end cylinder not set");
  a_crc_sets_both: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && ev.dataCrcFail)
    |=> (err1_q.crcFaultAnyField && err2_q.payloadCrcFault))
    else $error("data crc flags missing");
  a_mark_pair: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && ev.dataMarkMissing)
    |=> (err1_q.idSyncLost && err2_q.dataSyncLost)) else $error("mark pair missing");
  a_start_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    cmdStart |=> (err1_q == 8'h00 && err2_q == 8'h00)) else $error("start did not clear");
  a_protect_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && isWrite && writeProtect)
    |=> err1_q.writeBlockedFlag) else $error("write protect flag missing");
  a_overrun_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && svcTimeout) |=> err1_q.overrun)
    else $error("overrun not set");
  a_abnormal_code: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_RESULT && anyErr && !cmdStart) |=> (code_q == FDCR_IC_ABNORMAL))
    else $error("abnormal code missing");
  a_scan_equal: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FDCR_EXEC && !cmdStart && cmd_q == FDCR_CMD_SCAN && ev.scanEqual)
    |=> err2_q.compareEqualHit) else $error("scan equal not set");

  // last cycle of an executing command that is not being restarted
  sequence s_cmd_finish;
    (state_q == FDCR_EXEC) && !cmdStart && cmdEnd;
  endsequence : s_cmd_finish

  // an event cycle inside execution that is not being restarted
  sequence s_exec_cycle;
    (state_q == FDCR_EXEC) && !cmdStart;
  endsequence : s_exec_cycle

  a_target_missing: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_cmd_finish ##0 (!ev.targetFound && isScanOrRead(cmd_q)))
    |=> err1_q.sectorMissingFlag) else $error("missing sector not flagged");
  a_read_id_bad: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_cmd_finish ##0 (cmd_q == FDCR_CMD_READ_ID && !idGood_q && !ev.idReadGood))
    |=> err1_q.sectorMissingFlag) else $error("read id failure not flagged");
  a_track_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_cmd_finish ##0 (cmd_q == FDCR_CMD_READ_TRACK && !ev.targetFound))
    |=> err1_q.sectorMissingFlag) else $error("track start not flagged");
  a_index_lost: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_exec_cycle ##0 (ev.indexPulse && !idSeen_q && !ev.idMarkFound
      && indexCnt_q == FDCR_INDEX_LIMIT - 2'h1))
    |=> err1_q.idSyncLost) else $error("id mark loss not flagged");
  a_deleted_mark: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_exec_cycle ##0 (ev.deletedMark && isScanOrRead(cmd_q)))
    |=> err2_q.deletedSectorSeen) else $error("deleted mark not flagged");
  a_wrong_cyl: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_cmd_finish ##0 (!ev.targetFound && ev.idValid && ev.idCylinder != targetCyl_q))
    |=> err2_q.trackNumberMismatch) else $error("wrong cylinder not flagged");
  a_bad_cyl: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_cmd_finish ##0 (!ev.targetFound && ev.idValid && ev.idCylinder == FDCR_BAD_CYL
      && targetCyl_q != FDCR_BAD_CYL))
    |=> err2_q.damagedTrackFlag) else $error("bad cylinder not flagged");
  a_scan_nomatch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (s_exec_cycle ##0 (cmd_q == FDCR_CMD_SCAN && ev.scanDone && !ev.scanMatched))
    |=> err2_q.compareNoMatch) else $error("scan no match not flagged");
  a_flags_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cmdStart && state_q != FDCR_EXEC) |=> ($stable(err1_q) && $stable(err2_q)))
    else $error("flags changed outside execution");
endmodule : fdcr_result_flags
